// File: inc/scl_pkg.sv
// constants shared by the serial configuration loader
package scl_pkg;
    localparam int CLK_MHZ = 200;                  // core clock rate
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_MIN_NS = 500;              // least reprogram pulse
    localparam int PROG_CYC = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_CYC = 16;                 // memory clearing time
    localparam int HALF_W = 7;                     // half-period counter width
    localparam logic [5:0] RATE_START = 6'h01;     // slowest rate setting
    localparam logic [HALF_W-1:0] HALF_START = HALF_W'(CLK_MHZ / 2 / 1);
    localparam logic [HALF_W-1:0] HALF_MIN = 7'h04; // keeps sync margin
    localparam logic [2:0] MODE_SERIAL = 3'h0;
    localparam logic [2:0] MODE_SPI = 3'h1;
    localparam logic [2:0] VS_FAST = 3'h7;
    localparam logic [2:0] VS_READ = 3'h5;
    localparam logic [2:0] VS_ARRAY = 3'h6;
    localparam logic [7:0] CMD_FAST = 8'h0b;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_ARRAY = 8'he8;
    localparam logic [6:0] HDR_FAST = 7'h28;      // 8+24+8 bits
    localparam logic [6:0] HDR_READ = 7'h20;      // 8+24 bits
    localparam logic [6:0] HDR_ARRAY = 7'h40;     // 8+24+32 bits
    localparam int LEN_W = 23;                     // image length in bits
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 8;
    typedef enum logic [2:0] {ST_CLEAR, ST_WAIT_INIT, ST_HEADER, ST_LOAD, ST_DONE,
        ST_ERROR} scl_state_e;
endpackage

// File: rtl/scl_loader.sv
// serial configuration loader with its data fifo
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// small synchronous fifo, count based so full and empty are exact
module scl_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];            // storage words
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // pointer and count update
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? AW'((32'(wr_q) + 1) % D) : wr_q;
        rd_d = pop ? AW'((32'(rd_q) + 1) % D) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
    assign in_ready = (32'(cnt_q) != D);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    // registers; storage needs no reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// loader: sequences clear, mode sampling, header, load and hand-off
module scl_loader import scl_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reprogram_n,            // pin, active low
    input wire logic [2:0] mode_pins,        // pin straps
    input wire logic [2:0] read_variant_pins,// pin straps
    input wire logic init_in,                // open-drain pin level
    output logic init_out,
    output logic init_oe,
    output logic done_out,
    output logic done_oe,
    output logic cfg_clock_out,
    output logic flash_select_n,
    output logic mosi_out,
    input wire logic din,                    // serial data from memory
    output logic dout,                       // daisy-chain data out
    input wire logic [LEN_W-1:0] image_len,  // own image length in bits
    input wire logic rate_valid,             // bitstream rate request
    input wire logic [5:0] clock_rate_option,
    input wire logic crc_error,
    output logic [FIFO_W-1:0] cfg_data,
    output logic cfg_valid,
    input wire logic cfg_ready,
    input wire logic user_en,                // user owns pins after done
    input wire logic user_clk,
    input wire logic user_sel_n,
    input wire logic user_mosi,
    output logic user_din
);
    // two-flop synchronisers for every pin input
    logic [8:0] s1_q, s2_q;
    logic prog_s, init_s, din_s;
    logic [2:0] mode_s, vs_s;
    assign {prog_s, init_s, din_s, mode_s, vs_s} = s2_q;

    scl_state_e st_q, st_d;
    logic [6:0] prog_q, prog_d;              // low-time counter
    logic [4:0] clr_q, clr_d;
    logic [HALF_W-1:0] half_q, half_d, div_q, div_d;
    logic cfg_clock_out_q, cfg_clock_out_d, sel_q, sel_d, mosi_q, mosi_d, dout_q, dout_d;
    logic init_oe_q, init_oe_d, done_oe_q, done_oe_d;
    logic [63:0] hdr_q, hdr_d;
    logic [6:0] left_q, left_d;
    logic [2:0] mode_q, mode_d;
    logic [FIFO_W-1:0] sh_q, sh_d;
    logic [2:0] nb_q, nb_d;
    logic [LEN_W-1:0] bits_q, bits_d;
    logic rp1_q, rp2_q;                      // rise pulse aligned to din_s
    logic push_q, push_d;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [FIFO_W-1:0] fifo_out_data, cdata_q, cdata_d;
    logic cvalid_q, cvalid_d;
    logic run, tick, rise, fall, user_mode;
    logic [HALF_W-1:0] req_half;

    assign user_mode = (st_q == ST_DONE) && user_en;
    // clock runs while loading and, in serial mode, after done for chaining; it stalls when the fifo is full
    assign run = (st_q == ST_HEADER) || ((st_q == ST_LOAD) && fifo_in_ready)
        || ((st_q == ST_DONE) && !user_en && (mode_q == MODE_SERIAL));
    assign tick = run && (div_q == half_q - 7'h01);
    assign rise = tick && !cfg_clock_out_q;
    assign fall = tick && cfg_clock_out_q;
    // rate option approximates MHz: half period = clk_mhz / (2 * option)
    assign req_half = HALF_W'(CLK_MHZ / 2 / int'(clock_rate_option));
    assign fifo_pop = !cvalid_q || cfg_ready;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic for the whole sequencer
    always_comb begin
        st_d = st_q;
        prog_d = prog_s ? 7'h00 : ((32'(prog_q) < PROG_CYC) ? prog_q + 7'h01 : prog_q);
        clr_d = clr_q;
        half_d = half_q;
        div_d = run ? (tick ? '0 : div_q + 7'h01) : '0;
        cfg_clock_out_d = tick ? !cfg_clock_out_q : cfg_clock_out_q;
        sel_d = sel_q;
        mosi_d = mosi_q;
        dout_d = dout_q;
        init_oe_d = init_oe_q;
        done_oe_d = done_oe_q;
        hdr_d = hdr_q;
        left_d = left_q;
        mode_d = mode_q;
        sh_d = sh_q;
        nb_d = nb_q;
        bits_d = bits_q;
        push_d = 1'b0;
        if (rate_valid && clock_rate_option != 6'h00) begin
            half_d = (req_half < HALF_MIN) ? HALF_MIN : req_half;
        end
        unique case (st_q)
            ST_CLEAR: begin                 // memory clear: both indicators low
                init_oe_d = 1'b1;
                done_oe_d = 1'b1;
                sel_d = 1'b1;
                half_d = HALF_START;
                cfg_clock_out_d = 1'b0;
                clr_d = clr_q + 5'h01;
                if (32'(clr_q) == CLEAR_CYC - 1) begin
                    st_d = ST_WAIT_INIT;
                    init_oe_d = 1'b0;
                end
            end
            ST_WAIT_INIT: begin             // memory may hold init low longer
                if (init_s) begin
                    mode_d = mode_s;
                    bits_d = '0;
                    nb_d = '0;
                    left_d = '0;
                    st_d = ST_LOAD;
                    if (mode_s == MODE_SPI) begin
                        st_d = ST_HEADER;
                        sel_d = 1'b0;
                        if (vs_s == VS_FAST) begin
                            hdr_d = {CMD_FAST, 56'h0};
                            left_d = HDR_FAST;
                        end else if (vs_s == VS_READ) begin
                            hdr_d = {CMD_READ, 56'h0};
                            left_d = HDR_READ;
                        end else if (vs_s == VS_ARRAY) begin
                            hdr_d = {CMD_ARRAY, 56'h0};
                            left_d = HDR_ARRAY;
                        end else begin                         // reserved variant
                            st_d = ST_ERROR;
                            sel_d = 1'b1;
                        end
                        // the flash samples on the very first rise, so the first
                        // command bit leaves the shifter now and one fall less is due
                        if (st_d == ST_HEADER) begin
                            mosi_d = hdr_d[63];
                            hdr_d = {hdr_d[62:0], 1'b0};
                            left_d = left_d - 7'h01;
                        end
                    end else if (mode_s != MODE_SERIAL) begin
                        st_d = ST_ERROR;
                    end
                end
            end
            ST_HEADER: begin                // shift command, zero address, dummies
                if (fall) begin
                    if (left_q != 7'h00) begin
                        mosi_d = hdr_q[63];
                        hdr_d = {hdr_q[62:0], 1'b0};
                        left_d = left_q - 7'h01;
                    end else begin
                        mosi_d = 1'b0;
                        st_d = ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin                  // collect bits into bytes
                if (crc_error) begin
                    st_d = ST_ERROR;
                    init_oe_d = 1'b1;
                end else if (rp2_q) begin
                    sh_d = {sh_q[FIFO_W-2:0], din_s};
                    nb_d = nb_q + 3'h1;
                    bits_d = bits_q + LEN_W'(1);
                    push_d = (nb_q == 3'h7) || (bits_q + LEN_W'(1) == image_len);
                    if (bits_q + LEN_W'(1) == image_len) begin
                        st_d = ST_DONE;
                        done_oe_d = 1'b0;
                        sel_d = 1'b1;
                    end
                end
            end
            ST_DONE: begin                  // chain forward or user access
                if (user_en) begin
                    cfg_clock_out_d = user_clk;
                    sel_d = user_sel_n;
                    mosi_d = user_mosi;
                end else if (fall) begin
                    dout_d = din_s;
                end
            end
            ST_ERROR: begin
                init_oe_d = 1'b1;
                sel_d = 1'b1;
            end
        endcase
        if (prog_s && 32'(prog_q) == PROG_CYC) begin
            st_d = ST_CLEAR;
            clr_d = '0;
        end
        cvalid_d = fifo_pop ? fifo_out_valid : cvalid_q;
        cdata_d = (fifo_pop && fifo_out_valid) ? fifo_out_data : cdata_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers only; reset starts a power-up configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_q <= 9'h000;
            s2_q <= 9'h000;
            st_q <= ST_CLEAR;
            prog_q <= '0;
            clr_q <= '0;
            half_q <= HALF_START;
            div_q <= '0;
            cfg_clock_out_q <= 1'b0;
            sel_q <= 1'b1;
            mosi_q <= 1'b0;
            dout_q <= 1'b0;
            init_oe_q <= 1'b1;
            done_oe_q <= 1'b1;
            hdr_q <= '0;
            left_q <= '0;
            mode_q <= MODE_SERIAL;
            sh_q <= '0;
            nb_q <= '0;
            bits_q <= '0;
            rp1_q <= 1'b0;
            rp2_q <= 1'b0;
            push_q <= 1'b0;
            cdata_q <= '0;
            cvalid_q <= 1'b0;
        end else begin
            s1_q <= {reprogram_n, init_in, din, mode_pins, read_variant_pins};
            s2_q <= s1_q;
            st_q <= st_d;
            prog_q <= prog_d;
            clr_q <= clr_d;
            half_q <= half_d;
            div_q <= div_d;
            cfg_clock_out_q <= cfg_clock_out_d;
            sel_q <= sel_d;
            mosi_q <= mosi_d;
            dout_q <= dout_d;
            init_oe_q <= init_oe_d;
            done_oe_q <= done_oe_d;
            hdr_q <= hdr_d;
            left_q <= left_d;
            mode_q <= mode_d;
            sh_q <= sh_d;
            nb_q <= nb_d;
            bits_q <= bits_d;
            rp1_q <= rise && (st_q == ST_LOAD);
            rp2_q <= rp1_q;
            push_q <= push_d;
            cdata_q <= cdata_d;
            cvalid_q <= cvalid_d;
        end
    end

    // a partial last byte is pushed right-aligned as collected
    scl_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .clk(core_clk),
        .rst(rst),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(sh_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    assign init_out = 1'b0;          // open-drain: only ever pulls low
    assign done_out = 1'b0;
    assign init_oe = init_oe_q;
    assign done_oe = done_oe_q;
    assign cfg_clock_out = cfg_clock_out_q;
    assign flash_select_n = sel_q;
    assign mosi_out = mosi_q;
    assign dout = dout_q;
    assign cfg_data = cdata_q;
    assign cfg_valid = cvalid_q;
    assign user_din = din_s;         // second sync flop of the data pin

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    done_low_a: assert property ((st_q == ST_HEADER || st_q == ST_LOAD) |-> done_oe_q)
        else $error("done released during load");
    crc_init_a: assert property ((st_q == ST_LOAD && crc_error) |=> init_oe_q [*2])
        else $error("crc error did not pull init low");
    restart_a: assert property ((prog_s && 32'(prog_q) == PROG_CYC) |=>
        st_q == ST_CLEAR ##1 done_oe_q)
        else $error("long reprogram pulse did not restart");
    start_rate_a: assert property ((st_q == ST_WAIT_INIT && !rate_valid) |=>
        half_q == HALF_START)
        else $error("load did not start at slowest rate");
    spi_sel_a: assert property ((mode_q == MODE_SPI &&
        (st_q == ST_HEADER || st_q == ST_LOAD)) |-> !sel_q)
        else $error("select high during read");
    // on entry the first command bit already stands on mosi
    header_len_a: assert property ((st_q == ST_HEADER && $past(st_q) != ST_HEADER) |->
        ({mosi_q, hdr_q[63:57]} == CMD_FAST && left_q == HDR_FAST - 7'h01)
        || ({mosi_q, hdr_q[63:57]} == CMD_READ && left_q == HDR_READ - 7'h01)
        || ({mosi_q, hdr_q[63:57]} == CMD_ARRAY && left_q == HDR_ARRAY - 7'h01))
        else $error("command and dummy count mismatch");
    chain_edge_a: assert property (($changed(dout_q) && !user_mode) |->
        $past(fall) && !cfg_clock_out_q)
        else $error("chain data changed off falling edge");
    clk_tick_a: assert property (($changed(cfg_clock_out_q) && st_q != ST_DONE &&
        st_q != ST_CLEAR) |-> $past(tick))
        else $error("config clock toggled off divider");
    capture_a: assert property (rise && st_q == ST_LOAD && !crc_error |-> ##2 rp2_q)
        else $error("rising edge not captured");

    spi_done_c: cover property (mode_q == MODE_SPI && st_q == ST_LOAD ##[1:1000] st_q == ST_DONE);
    chain_c: cover property (st_q == ST_DONE && mode_q == MODE_SERIAL && fall);
    crc_c: cover property (st_q == ST_LOAD && crc_error);
    stall_c: cover property (st_q == ST_LOAD && !fifo_in_ready);
endmodule

`default_nettype wire

// File: tb/scl_mem_model.sv
// stand-in for the serial memory: spi flash or plain serial prom
`timescale 1ns/10ps
`default_nettype none
module scl_mem_model (
    input wire logic mrst,
    input wire logic spi_mode,
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] cmd_seen,
    output logic [23:0] addr_seen
);
    int hdr_cnt;        // header bits taken in
    int bit_idx;        // data bit now on the line
    logic drv;          // data phase
    logic [31:0] sh;    // header shifter
    // images stored back to back as one byte stream, msb first
    function automatic logic pbit(int i);
        logic [7:0] b;
        b = 8'(8'h3c ^ (i / 8) * 37);
        return b[7 - i % 8];
    endfunction
    // header length decoded from the command, dummies included
    function automatic int hlen(logic [7:0] c);
        return (c == 8'h0b) ? 40 : (c == 8'h03) ? 32 : (c == 8'he8) ? 64 : 999;
    endfunction
    // a released line shows the inverse of the bit, never a held value
    assign miso = (drv && !(spi_mode && sel_n)) ? pbit(bit_idx) : ~pbit(bit_idx);
    // address counter cleared while init is low or, in spi mode, select is high
    always @(mrst or sel_n or spi_mode) begin
        if (mrst || (spi_mode && sel_n)) begin
            hdr_cnt = 0;
            bit_idx = 0;
            drv = !spi_mode;
        end
    end
    // command and address taken on the rising edge
    always @(posedge sck) begin
        if (!mrst && spi_mode && !sel_n && !drv) begin
            sh = {sh[30:0], mosi};
            hdr_cnt++;
            if (hdr_cnt == 8) cmd_seen = sh[7:0];
            if (hdr_cnt == 32) addr_seen = sh[23:0];
        end
    end
    // data moves after the falling edge, so it is steady at the rise
    always @(negedge sck) begin
        if (!mrst && !(spi_mode && sel_n)) begin
            if (drv) bit_idx++;
            else if (spi_mode && hdr_cnt >= hlen(cmd_seen)) drv = 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// top-level bench for the serial configuration loader
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import scl_pkg::*;
    logic core_clk, rst, reprogram_n, din, dout, init_oe, done_oe, init_out, done_out;
    logic cfg_clock_out, flash_select_n, mosi_out, rate_valid, crc_error, cfg_valid;
    logic cfg_ready, user_en, user_clk, user_sel_n, user_mosi, user_din, mem_spi;
    logic [2:0] mode_pins, read_variant_pins;
    logic [LEN_W-1:0] image_len;
    logic [5:0] clock_rate_option;
    logic [FIFO_W-1:0] cfg_data;
    logic [7:0] cmd_seen;
    logic [23:0] addr_seen;
    logic [7:0] got_q[$];       // bytes taken from the fifo
    int bad_count, checks_done;
    wire logic init_wire = ~init_oe;    // pulled up unless the block pulls it low

    scl_loader dut (.core_clk, .rst, .reprogram_n, .mode_pins, .read_variant_pins,
        .init_in(init_wire), .init_out, .init_oe, .done_out, .done_oe, .cfg_clock_out,
        .flash_select_n, .mosi_out, .din, .dout, .image_len, .rate_valid,
        .clock_rate_option, .crc_error, .cfg_data, .cfg_valid, .cfg_ready, .user_en,
        .user_clk, .user_sel_n, .user_mosi, .user_din);
    // memory address counter is held clear while init is low
    scl_mem_model mem (.mrst(rst || !init_wire), .spi_mode(mem_spi), .sck(cfg_clock_out),
        .sel_n(flash_select_n), .mosi(mosi_out), .miso(din), .cmd_seen, .addr_seen);

    ////////////////////////////////////////////////////////////////////////////
    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // collect every byte handed over
    always @(posedge core_clk) begin
        if (cfg_valid === 1'b1 && cfg_ready === 1'b1) got_q.push_back(cfg_data);
    end

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
    endtask
    // cycles up to the next rising link clock edge, bounded so a dead clock ends
    task automatic rise(output int n);
        n = 0;
        while (cfg_clock_out !== 1'b0 && n < 3000) begin
            cyc(1);
            n++;
        end
        while (cfg_clock_out !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic wait_done();
        int n = 0;
        while (done_oe !== 1'b0 && n < 40000) begin
            cyc(1);
            n++;
        end
        cyc(20);
    endtask
    task automatic check_bytes(int n);
        chk("byte count", n, got_q.size());
        for (int k = 0; k < n && k < got_q.size(); k++) begin
            chk("byte", 8'(8'h3c ^ k * 37), got_q[k]);
        end
    endtask
    // long reprogram pulse with new straps; the block must clear again
    task automatic restart(logic [2:0] m, logic [2:0] vs, int len, logic sp);
        @(posedge core_clk);
        mode_pins <= m;
        read_variant_pins <= vs;
        image_len <= LEN_W'(len);
        mem_spi <= sp;
        reprogram_n <= 1'b0;
        cyc(PROG_CYC + 5);
        reprogram_n <= 1'b1;
        cyc(6);
        chk("init_oe clear", 1, init_oe);
        chk("done_oe clear", 1, done_oe);
        got_q.delete();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // serial load, straps moved late, chain forwarding, short pulse ignored
    task automatic t_serial();
        int n;
        logic [8:0] di, dq;
        restart(3'h0, 3'h7, 16, 1'b0);
        cyc(40);
        mode_pins <= 3'h1;
        wait_done();
        check_bytes(2);
        for (int k = 0; k < 9; k++) begin
            rise(n);
            di[k] = din;
            dq[k] = dout;
        end
        for (int k = 0; k < 8; k++) chk("chain bit", di[k], dq[k + 1]);
        reprogram_n <= 1'b0;
        cyc(50);
        reprogram_n <= 1'b1;
        cyc(20);
        chk("short pulse", 0, done_oe);
    endtask
    // spi load for one variant, optional rate change and fifo stall
    task automatic t_spi(logic [2:0] vs, logic [7:0] cmd, logic [5:0] opt, int half,
            logic stall);
        int n, p;
        int len = stall ? 96 : 24;
        restart(3'h1, vs, len, 1'b1);
        cfg_ready <= !stall;
        rise(n);
        rise(p);
        chk("start period", 200, p);
        if (opt != 6'h00) begin
            rate_valid <= 1'b1;
            clock_rate_option <= opt;
            cyc(1);
            rate_valid <= 1'b0;
            rise(n);
            rise(p);
            chk("fast period", 2 * half, p);
        end
        if (stall) begin
            cyc(4000);
            p = 0;
            n[0] = cfg_clock_out;
            for (int k = 0; k < 200; k++) begin
                cyc(1);
                p += (cfg_clock_out !== n[0]);
                n[0] = cfg_clock_out;
            end
            chk("stalled clock edges", 0, p);
            chk("load still open", 1, done_oe);
            chk("fifo holding", 1, cfg_valid);
            cfg_ready <= 1'b1;
        end
        wait_done();
        chk("command", cmd, cmd_seen);
        chk("address", 0, addr_seen);
        chk("select after load", 1, flash_select_n);
        chk("fifo empty", 0, cfg_valid);
        check_bytes(len / 8);
    endtask
    // user logic takes the pins once configured
    task automatic t_user();
        @(posedge core_clk);
        user_en <= 1'b1;
        user_clk <= 1'b1;
        user_sel_n <= 1'b0;
        user_mosi <= 1'b1;
        cyc(4);
        chk("user clock", 1, cfg_clock_out);
        chk("user select", 0, flash_select_n);
        chk("user mosi", 1, mosi_out);
        chk("user din", din, user_din);
        user_en <= 1'b0;
    endtask
    // reserved variant or mode: init held low, no clock
    task automatic t_err(logic [2:0] m, logic [2:0] vs);
        int n;
        restart(m, vs, 24, 1'b1);
        rise(n);
        chk("no clock", 1, n >= 3000);
        chk("error init", 1, init_oe);
        chk("error select", 1, flash_select_n);
    endtask
    // crc error part way through a serial load
    task automatic t_crc();
        restart(3'h0, 3'h7, 1000, 1'b0);
        cyc(3000);
        crc_error <= 1'b1;
        cyc(1);
        crc_error <= 1'b0;
        cyc(5);
        chk("crc init", 1, init_oe);
        chk("crc done", 1, done_oe);
    endtask

    task automatic summarize();
        $display("checks_done %0d bad_count %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog sized well above the roughly 33k cycles the tests need
    initial begin
        cyc(80000);
        bad_count++;
        $display("BAD watchdog expected finish seen timeout");
        summarize();
    end

    initial begin
        {rst, reprogram_n, rate_valid, crc_error, cfg_ready, mem_spi} = 6'h23;
        {user_en, user_clk, user_sel_n, user_mosi} = 4'h2;
        mode_pins = 3'h0;
        read_variant_pins = 3'h7;
        image_len = LEN_W'(16);
        clock_rate_option = 6'h00;
        cyc(3);
        chk("reset init_oe", 1, init_oe);
        chk("reset done_oe", 1, done_oe);
        chk("reset select", 1, flash_select_n);
        cyc(2);
        rst <= 1'b0;
        t_serial();
        t_spi(3'h5, 8'h03, 6'h00, 100, 1'b0);
        t_user();
        t_spi(3'h7, 8'h0b, 6'h19, 4, 1'b1);
        t_spi(3'h6, 8'he8, 6'h0a, 10, 1'b0);
        t_err(3'h1, 3'h0);
        t_err(3'h2, 3'h7);
        t_crc();
        summarize();
    end
endmodule
`default_nettype wire
